/* hdl/dma_trigger_regs.vh */
/*
  Register offsets, field positions, reset values and trigger source codes
  for the DMA channel trigger select block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DMA_TRIGGER_REGS_VH
`define DMA_TRIGGER_REGS_VH

// Byte offsets on the Wishbone slave
`define TRIG_SELECT_OFFSET     8'h00
`define CHAN_CONTROL_OFFSET    8'h04
`define CHAN_STATUS_OFFSET     8'h08
`define ADDR_WIDTH             8

// Trigger select register layout
`define TRIG_SELECT_RESET      16'h0000
`define TRIG_FORCE_BIT         15
`define TRIG_CODE_MSB          7
`define TRIG_CODE_LSB          0
`define TRIG_CODE_WIDTH        8
`define TRIG_CODE_RESET        8'h00

// Channel control register layout
`define CTRL_ENABLE_BIT        0
`define CTRL_RESET             1'h0

// Channel status register layout
`define STAT_BUSY_BIT          0
`define STAT_FORCED_BIT        1
`define STAT_COUNT_LSB         8
`define STAT_COUNT_WIDTH       8

// Trigger source codes
`define SRC_EXT_INT0           8'h00
`define SRC_CAPTURE_ONE        8'h01
`define SRC_OUTPUT_COMPARE_ONE 8'h02
`define SRC_CAPTURE_TWO        8'h05
`define SRC_OUTPUT_COMPARE_TWO 8'h06
`define SRC_TIMER_TWO          8'h07
`define SRC_TIMER_THREE        8'h08
`define SRC_SERIAL_IFACE_DONE  8'h0A
`define SRC_SERIAL_PORT_RX     8'h0B
`define SRC_SERIAL_PORT_TX     8'h0C
`define SRC_ADC_ONE            8'h0D
`define SRC_OUTPUT_COMPARE_3   8'h19
`define SRC_OUTPUT_COMPARE_4   8'h1A
`define SRC_TIMER_FOUR         8'h1B
`define SRC_TIMER_FIVE         8'h1C
`define SRC_SERIAL_PORT2_RX    8'h1E
`define SRC_SERIAL_PORT2_TX    8'h1F
`define SRC_SERIAL_IFACE2_DONE 8'h21
`define SRC_CAPTURE_THREE      8'h25
`define SRC_CAPTURE_FOUR       8'h26

// Request line count
`define REQ_LINES              20

// Cycle count at which the internal budget ends a transfer
`define XFER_CYCLES            4'h3

`endif

/* hdl/trigger_source_mux.v */
/*
  Trigger source multiplexer: maps an eight-bit code to one request line.
  Assumes request lines are synchronous to clock; unknown codes select none.
*/
`timescale 1ns/1ps
`include "dma_trigger_regs.vh"

module trigger_source_mux (
  // Clock
  input  wire                          clock,
  input  wire                          reset,
  // Selection
  input  wire [`TRIG_CODE_WIDTH-1:0]   code,
  input  wire [`REQ_LINES-1:0]         requests,
  // Result, registered
  output reg                           selected_reg
);

  // Code table, one entry per request line
  wire [`TRIG_CODE_WIDTH*`REQ_LINES-1:0] code_table;
  assign code_table = {`SRC_CAPTURE_FOUR, `SRC_CAPTURE_THREE, `SRC_SERIAL_IFACE2_DONE,
                       `SRC_SERIAL_PORT2_TX, `SRC_SERIAL_PORT2_RX, `SRC_TIMER_FIVE,
                       `SRC_TIMER_FOUR, `SRC_OUTPUT_COMPARE_4, `SRC_OUTPUT_COMPARE_3,
                       `SRC_ADC_ONE, `SRC_SERIAL_PORT_TX, `SRC_SERIAL_PORT_RX,
                       `SRC_SERIAL_IFACE_DONE, `SRC_TIMER_THREE, `SRC_TIMER_TWO,
                       `SRC_OUTPUT_COMPARE_TWO, `SRC_CAPTURE_TWO,
                       `SRC_OUTPUT_COMPARE_ONE, `SRC_CAPTURE_ONE, `SRC_EXT_INT0};

  wire [`REQ_LINES-1:0] hit;   // One-hot match per line

  // Per-line comparison; only the line whose code matches passes
  genvar i;
  generate
    for (i = 0; i < `REQ_LINES; i = i + 1) begin : g_match
      assign hit[i] = requests[i] &&
                      (code == code_table[i*`TRIG_CODE_WIDTH +: `TRIG_CODE_WIDTH]);
    end
  endgenerate

  // Register the selected request so the caller sees a clean level
  always @(posedge clock) begin
    if (reset) begin
      selected_reg <= 1'b0;
    end else begin
      selected_reg <= |hit;
    end
  end

endmodule

/* hdl/dma_channel_request_select.v */
/*
  DMA channel trigger selection with a Wishbone classic register slave.
  Holds the trigger select register (manual force bit and source code), a
  channel control register with the enable bit, and a status register.
  Assumes peripheral request lines are synchronous levels on clock, and a
  classic single-cycle Wishbone master that waits for ack.
*/
// Notes on behaviour
// - Force bit makes exactly one transfer.
// - Bits 14 to 8 read zero, ignore writes.
// - Low-byte code routes request; 0x0B serial receive.
// - Code 0x0A selects serial interface done.
// - Code 0x02 selects output compare one.
// - Software clears force only by disabling the channel; hardware clears it.
`timescale 1ns/1ps
`include "dma_trigger_regs.vh"

module dma_channel_request_select (
  // Clock and reset
  input  wire                          clock,
  input  wire                          reset,
  // Wishbone classic slave
  input  wire                          wb_cyc_i,
  input  wire                          wb_stb_i,
  input  wire                          wb_we_i,
  input  wire [`ADDR_WIDTH-1:0]        wb_adr_i,
  input  wire [3:0]                    wb_sel_i,
  input  wire [31:0]                   wb_dat_i,
  output reg  [31:0]                   wb_dat_o,
  output reg                           wb_ack_o,
  // Peripheral request lines, indexed by table position
  input  wire                          ext_int0,
  input  wire                          capture_one,
  input  wire                          output_compare_one,
  input  wire                          capture_two,
  input  wire                          output_compare_two,
  input  wire                          timer_two,
  input  wire                          timer_three,
  input  wire                          serial_iface_one_done,
  input  wire                          serial_port_one_receive,
  input  wire                          serial_port_one_transmit,
  input  wire                          adc_one_done,
  input  wire                          output_compare_three,
  input  wire                          output_compare_four,
  input  wire                          timer_four,
  input  wire                          timer_five,
  input  wire                          serial_port_two_receive,
  input  wire                          serial_port_two_transmit,
  input  wire                          serial_iface_two_done,
  input  wire                          capture_three,
  input  wire                          capture_four,
  // Transfer datapath handshake
  input  wire                          xfer_done,
  output reg                           xfer_start_reg,
  output reg                           xfer_busy_reg
);

  // State codes of the transfer sequencer
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_WAIT = 2'b10;

  // Registers
  reg                          force_reg;          // Manual trigger bit
  reg  [`TRIG_CODE_WIDTH-1:0]  trigger_source_code_reg;
  reg                          channel_enable_bit_reg;
  reg  [1:0]                   state_reg;          // Sequencer state
  reg  [1:0]                   state_next;
  reg  [3:0]                   cycle_count_reg;    // Cycles spent in a transfer
  reg                          forced_xfer_reg;    // Current transfer is a forced one
  reg  [`STAT_COUNT_WIDTH-1:0] xfer_count_reg;     // Completed transfers, wraps
  reg                          request_prev_reg;   // Last sample of selected request

  // Combinational helpers
  wire [`REQ_LINES-1:0]        request_bus;        // Lines in table order
  wire                         request_level;      // Selected line, registered in mux
  wire                         request_edge;       // Rising edge of the selected line
  wire                         bus_access;         // Valid strobe without pending ack
  wire                         bus_write;
  wire                         xfer_finished;      // End of current transfer
  wire                         start_now;          // Transfer begins this cycle
  wire                         force_write;        // Software sets the manual trigger bit

  assign request_bus = {capture_four, capture_three, serial_iface_two_done,
                        serial_port_two_transmit, serial_port_two_receive, timer_five,
                        timer_four, output_compare_four, output_compare_three,
                        adc_one_done, serial_port_one_transmit, serial_port_one_receive,
                        serial_iface_one_done, timer_three, timer_two,
                        output_compare_two, capture_two, output_compare_one,
                        capture_one, ext_int0};

  // Source selection; the mux registers its result, one cycle of latency
  trigger_source_mux source_mux (
    .clock        (clock),
    .reset        (reset),
    .code         (trigger_source_code_reg),
    .requests     (request_bus),
    .selected_reg (request_level)
  );

  // A held request level counts once, so a stuck line cannot flood the channel
  assign request_edge  = request_level && !request_prev_reg;
  assign bus_access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write     = bus_access && wb_we_i;
  assign force_write   = bus_write && (wb_adr_i == `TRIG_SELECT_OFFSET) && wb_sel_i[1] &&
                         wb_dat_i[`TRIG_FORCE_BIT];
  // Datapath done, or an internal cycle budget when the datapath never answers
  assign xfer_finished = (state_reg == ST_RUN) &&
                         (xfer_done || (cycle_count_reg == `XFER_CYCLES));
  // Force wins over a peripheral request; neither starts while disabled
  assign start_now     = (state_reg == ST_IDLE) && channel_enable_bit_reg &&
                         (force_reg ? !forced_xfer_reg : request_edge);

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_now) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!channel_enable_bit_reg) begin
          state_next = ST_IDLE;           // Disable aborts the transfer
        end else if (xfer_finished) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        state_next = ST_IDLE;             // One wait cycle, then idle: two cycles between transfers
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state, cycle counter and outputs to the datapath
  always @(posedge clock) begin
    if (reset) begin
      state_reg        <= ST_IDLE;
      cycle_count_reg  <= 4'h0;
      xfer_start_reg   <= 1'b0;
      xfer_busy_reg    <= 1'b0;
      request_prev_reg <= 1'b0;
      xfer_count_reg   <= {`STAT_COUNT_WIDTH{1'b0}};
    end else begin
      state_reg        <= state_next;
      request_prev_reg <= request_level;
      xfer_start_reg   <= start_now;      // One-cycle pulse per transfer
      xfer_busy_reg    <= (state_next == ST_RUN);
      if (state_reg == ST_RUN) begin
        cycle_count_reg <= cycle_count_reg + 4'h1;
      end else begin
        cycle_count_reg <= 4'h0;
      end
      if (xfer_finished && channel_enable_bit_reg) begin
        xfer_count_reg <= xfer_count_reg + 8'h01;
      end
    end
  end

  // Force bit: software sets it, or clears it by disabling the channel; hardware clears it
  always @(posedge clock) begin
    if (reset) begin
      force_reg       <= 1'b0;
      forced_xfer_reg <= 1'b0;
    end else begin
      if (!channel_enable_bit_reg) begin
        force_reg       <= 1'b0;
        forced_xfer_reg <= 1'b0;
      end else if (xfer_finished && forced_xfer_reg) begin
        // A set in the finishing cycle wins, so a new manual request is not lost
        force_reg       <= force_write;
        forced_xfer_reg <= 1'b0;
      end else begin
        if (start_now && force_reg) begin
          forced_xfer_reg <= 1'b1;
        end
        // A write of one sets; a write of zero is ignored
        if (force_write) begin
          force_reg <= 1'b1;
        end
      end
    end
  end

  // Software-written configuration
  always @(posedge clock) begin
    if (reset) begin
      trigger_source_code_reg <= `TRIG_CODE_RESET;
      channel_enable_bit_reg  <= `CTRL_RESET;
    end else if (bus_write) begin
      if (wb_adr_i == `TRIG_SELECT_OFFSET && wb_sel_i[0]) begin
        trigger_source_code_reg <= wb_dat_i[`TRIG_CODE_MSB:`TRIG_CODE_LSB];
      end
      if (wb_adr_i == `CHAN_CONTROL_OFFSET && wb_sel_i[0]) begin
        channel_enable_bit_reg <= wb_dat_i[`CTRL_ENABLE_BIT];
      end
    end
  end

  // Bus answer: ack one cycle after the strobe, read data with it
  always @(posedge clock) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_access;
      wb_dat_o <= 32'h00000000;
      if (bus_access && !wb_we_i) begin
        case (wb_adr_i)
          `TRIG_SELECT_OFFSET: begin
            // Bits 14 to 8 and above 15 are held at zero
            wb_dat_o <= {16'h0000, force_reg, 7'h00, trigger_source_code_reg};
          end
          `CHAN_CONTROL_OFFSET: begin
            wb_dat_o <= {31'h00000000, channel_enable_bit_reg};
          end
          `CHAN_STATUS_OFFSET: begin
            wb_dat_o <= {16'h0000, xfer_count_reg, 6'h00, forced_xfer_reg, xfer_busy_reg};
          end
          default: begin
            wb_dat_o <= 32'h00000000;     // Unmapped reads zero, still acked
          end
        endcase
      end
    end
  end

endmodule

/* bench/dma_select_properties.sv */
/*
  Concurrent checks on the trigger select block ports.
  Assumes a bind to the top module and a classic Wishbone master.
*/
`timescale 1ns/1ps
module dma_select_properties (
  // Clock and reset
  input wire        clock,
  input wire        reset,
  // Register bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Watched request lines
  input wire        output_compare_one,
  input wire        serial_iface_one_done,
  input wire        serial_port_one_receive,
  // Transfer handshake
  input wire        xfer_start_reg,
  input wire        xfer_busy_reg
);
  reg  [7:0] code_reg;  // Shadow of the source code
  reg        en_reg;    // Shadow of the enable
  wire       wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire       frc = wr & wb_sel_i[1] & wb_dat_i[15] & (wb_adr_i == 8'h00);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Shadows follow taken writes, so routing is known without the bodies
  always @(posedge clock) begin
    if (reset) begin
      code_reg <= 8'h00;
      en_reg   <= 1'b0;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == 8'h00) code_reg <= wb_dat_i[7:0];
      if (wb_adr_i == 8'h04) en_reg <= wb_dat_i[0];
    end
  end
  force_start_a: assert property (frc && en_reg |-> ##[1:12] xfer_start_reg)
    else $error("forced transfer missing");
  single_start_a: assert property (xfer_start_reg |=> !xfer_start_reg [*2])
    else $error("second start too soon");
  reserved_zero_a: assert property (wb_ack_o && wb_adr_i == 8'h00 |-> wb_dat_o[14:8] == 7'h00)
    else $error("reserved bits not zero");
  rx_route_a: assert property ($rose(serial_port_one_receive) && code_reg == 8'h0B && en_reg
    && !xfer_busy_reg && !$past(xfer_busy_reg) |-> ##[2:3] xfer_start_reg)
    else $error("receive request not routed");
  spi_route_a: assert property ($rose(serial_iface_one_done) && code_reg == 8'h0A && en_reg
    && !xfer_busy_reg && !$past(xfer_busy_reg) |-> ##[2:3] xfer_start_reg)
    else $error("serial done not routed");
  oc_route_a: assert property ($rose(output_compare_one) && code_reg == 8'h02 && en_reg
    && !xfer_busy_reg && !$past(xfer_busy_reg) |-> ##[2:3] xfer_start_reg)
    else $error("compare request not routed");
  off_quiet_a: assert property (!en_reg && !$past(en_reg) |-> !xfer_start_reg)
    else $error("start while disabled");
  unselected_ignored_a: assert property ($rose(serial_port_one_receive) && code_reg != 8'h0B
    && !output_compare_one && !serial_iface_one_done |-> ##2 !xfer_start_reg ##1 !xfer_start_reg)
    else $error("unselected request started");
endmodule

/* bench/peripheral_model.sv */
/*
  Peripheral side: request levels and a datapath that ends transfers.
  Assumes the bench calls fire from its own process after a clock edge.
*/
`timescale 1ns/1ps
module peripheral_model (
  // Clock
  input  wire        clock,
  // Datapath handshake
  input  wire        xfer_start,
  input  wire        slow,
  output reg         xfer_done = 1'b0,
  // Request levels, table order
  output reg  [19:0] req = 20'h00000
);
  // Raise one request for two cycles; a short level keeps one edge only
  task fire(input integer n);
    begin
      @(posedge clock) req[n] <= 1'b1;
      repeat (2) @(posedge clock);
      req[n] <= 1'b0;
    end
  endtask
  // Prompt answer, or none when slow so the internal budget must end it
  always @(posedge clock) begin
    xfer_done <= xfer_start & ~slow;
  end
endmodule

/* bench/test_dma_channel_request_select.sv */
/*
  Register-level bench for the trigger select block.
  Assumes the peripheral model and the property checker are compiled first.
*/
`timescale 1ns/1ps
module test_dma_channel_request_select;
  reg         clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, slow;
  reg  [7:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i, q;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, xfer_done, xfer_start_reg, xfer_busy_reg;
  wire [19:0] r;
  integer     n_errors = 0, compares = 0, n_start = 0, s, k;
  logic [7:0] codes [20] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A,
    8'h0B, 8'h0C, 8'h0D, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h25, 8'h26};
  dma_channel_request_select uut (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_int0(r[0]),
    .capture_one(r[1]), .output_compare_one(r[2]), .capture_two(r[3]),
    .output_compare_two(r[4]), .timer_two(r[5]), .timer_three(r[6]),
    .serial_iface_one_done(r[7]), .serial_port_one_receive(r[8]),
    .serial_port_one_transmit(r[9]), .adc_one_done(r[10]), .output_compare_three(r[11]),
    .output_compare_four(r[12]), .timer_four(r[13]), .timer_five(r[14]),
    .serial_port_two_receive(r[15]), .serial_port_two_transmit(r[16]),
    .serial_iface_two_done(r[17]), .capture_three(r[18]), .capture_four(r[19]),
    .xfer_done(xfer_done), .xfer_start_reg(xfer_start_reg), .xfer_busy_reg(xfer_busy_reg));
  peripheral_model pm (.clock(clock), .xfer_start(xfer_start_reg), .slow(slow),
    .xfer_done(xfer_done), .req(r));
  // Free-running clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Count starts seen on the datapath side
  always @(posedge clock) begin
    if (xfer_start_reg === 1'b1) n_start <= n_start + 1;
  end
  task report_and_stop;
    begin
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One classic cycle; data is taken at the edge where ack is sampled high
  task wb_cycle(input [7:0] a, input w, input [31:0] d, input [3:0] sl);
    integer i;
    begin
      @(posedge clock);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      wb_adr_i <= a;
      wb_sel_i <= sl;
      wb_dat_i <= d;
      i = 0;
      do begin
        @(posedge clock);
        i = i + 1;
      end while (wb_ack_o !== 1'b1 && i < 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (i >= 20) begin
        n_errors = n_errors + 1;
        report_and_stop;
      end
    end
  endtask
  initial begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i, slow} = 5'b10000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    wb_cycle(8'h00, 1'b0, 0, 4'hF);
    check(q, 32'h00000000);
    wb_cycle(8'h00, 1'b1, 32'h00008000, 4'h3);
    wb_cycle(8'h00, 1'b0, 0, 4'hF);
    check(q, 32'h00000000);
    wb_cycle(8'h00, 1'b1, 32'hFFFF7F5A, 4'hF);
    wb_cycle(8'h00, 1'b0, 0, 4'hF);
    check(q, 32'h0000005A);
    wb_cycle(8'h10, 1'b0, 0, 4'hF);
    check(q, 32'h00000000);
    check(n_start, 0);
    wb_cycle(8'h04, 1'b1, 1, 4'h1);
    // Every code: a neighbour line is ignored, the chosen line starts once
    for (k = 0; k < 20; k = k + 1) begin
      wb_cycle(8'h00, 1'b1, {24'h0, codes[k]}, 4'h1);
      s = n_start;
      pm.fire((k + 1) % 20);
      repeat (8) @(posedge clock);
      check(n_start - s, 0);
      pm.fire(k);
      @(posedge clock);
      check(xfer_busy_reg, 1);
      repeat (7) @(posedge clock);
      check(n_start - s, 1);
    end
    wb_cycle(8'h04, 1'b0, 0, 4'hF);
    check(q, 32'h00000001);
    wb_cycle(8'h08, 1'b0, 0, 4'hF);
    check(q, 32'h00001400);
    // Forced transfer with a stalled datapath; the budget must end it
    slow <= 1'b1;
    s = n_start;
    wb_cycle(8'h00, 1'b1, 32'h0000800B, 4'h3);
    wb_cycle(8'h00, 1'b0, 0, 4'hF);
    check(q, 32'h0000800B);
    repeat (12) @(posedge clock);
    wb_cycle(8'h00, 1'b0, 0, 4'hF);
    check(q, 32'h0000000B);
    check(n_start - s, 1);
    // Disable during a forced transfer: force drops and stays dropped on re-enable
    s = n_start;
    wb_cycle(8'h00, 1'b1, 32'h0000800B, 4'h3);
    wb_cycle(8'h04, 1'b1, 0, 4'h1);
    wb_cycle(8'h04, 1'b1, 1, 4'h1);
    repeat (12) @(posedge clock);
    wb_cycle(8'h00, 1'b0, 0, 4'hF);
    check(q, 32'h0000000B);
    check(n_start - s, 1);
    wb_cycle(8'h08, 1'b0, 0, 4'hF);
    check(q, 32'h00001500);
    report_and_stop;
  end
endmodule
bind dma_channel_request_select dma_select_properties chk (.clock, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .output_compare_one, .serial_iface_one_done, .serial_port_one_receive,
  .xfer_start_reg, .xfer_busy_reg);
